// [verilog/adc_conv_params.svh]
// Register map, field positions, reset values and timing counts of the conversion controller
`ifndef ADC_CONV_PARAMS_SVH
`define ADC_CONV_PARAMS_SVH

// Word indexes on the Avalon address
`define REG_MAIN      3'h0
`define REG_CLKDIV    3'h1
`define REG_REFSEL    3'h2
`define REG_RES_LOW   3'h3
`define REG_RES_HIGH  3'h4
`define REG_INT_STAT  3'h5
`define REG_INT_MASK  3'h6
`define REG_GLOB_EN   3'h7

// Field positions
`define MAIN_START    7
`define MAIN_BUSY     6
`define MAIN_PDOWN    5
`define POS_REF_HI    3
`define POS_REF_LO    2
`define NEG_REF_HI    1
`define NEG_REF_LO    0
`define INT_DONE_BIT  0

// Reset values
`define PDOWN_RESET   1'b1
`define BUSY_RESET    1'b1
`define CHAN_RESET    3'h0
`define DIV_RESET     3'h0
`define REF_RESET     2'h0

// Reference select codes and one-hot switch drives
`define REF_CODE_FIX  2'h0
`define REF_CODE_PIN  2'h1
`define REF_SW_FIX    3'h1
`define REF_SW_PIN    3'h2
`define REF_SW_ALT    3'h4

// Conversion length in A/D clock periods
`define CONV_TICKS    5'h10
`define CONV_LAST     4'hf

`endif

// [verilog/adc_conv_pkg.sv]
// Types shared by the conversion controller
package adc_conv_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_CONV = 2'b10
   } conv_state_t;
   typedef logic [2:0] field3_t;
endpackage

// [verilog/adc_clk_divider.sv]
// A/D clock enable divider, power-of-two ratios
`timescale 1ns/1ps
`default_nettype none
module adc_clk_divider (
   input  wire logic                mclk,
   input  wire logic                reset,
   input  wire logic                restart,
   input  wire adc_conv_pkg::field3_t div_sel,
   output var  logic                tick
);
   import adc_conv_pkg::*;

   logic [5:0] cnt_r;
   logic [5:0] mask;

   // Code 111 wraps to the widest mask, so it divides by 64
   assign mask = 6'((7'h01 << div_sel) - 7'h01);

   always_ff @(posedge mclk) begin
      if (reset || restart) begin
         cnt_r <= 6'h00;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // [RULE_10] one tick per ratio
   always_ff @(posedge mclk) begin
      if (reset || restart) begin
         tick <= 1'b0;
      end else begin
         tick <= ((cnt_r & mask) == mask);
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_tick_spacing;
      tick && $stable(div_sel) && div_sel != 3'h0 && !restart |=> !tick;
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("divider ticked on consecutive cycles"); // [RULE_10]
endmodule // adc_clk_divider
`default_nettype wire

// [verilog/adc_irq_ctrl.sv]
// Sticky conversion-done status with mask and global gate
`timescale 1ns/1ps
`default_nettype none
module adc_irq_ctrl (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic event_set,
   input  wire logic clr_wr,
   input  wire logic clr_bit,
   input  wire logic mask_en,
   input  wire logic global_en,
   output var  logic status,
   output var  logic irq
);
   import adc_conv_pkg::*;

   // [RULE_05] set beats clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         status <= 1'b0;
      end else begin
         status <= event_set | (status & ~(clr_wr & clr_bit));
      end
   end

   // [RULE_06] both enables required
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= status & mask_en & global_en;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_set_wins;
      event_set |=> status;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("status lost a set"); // [RULE_05]
endmodule // adc_irq_ctrl
`default_nettype wire

// [verilog/adc_conversion_control.sv]
// A/D conversion controller: Avalon registers, start handshake, timing and routing
// Functional notes
// [RULE_01] Channel field routes one of eight inputs
// [RULE_02] Start high then low launches conversion
// [RULE_03] Start rising resets converter, sets busy
// [RULE_04] Busy high while converting, clears at end
// [RULE_05] End of conversion sets interrupt request
// [RULE_06] Interrupt needs global and converter enable
// [RULE_07] Power-down bit, reset value one
// [RULE_08] Software waits settling time after power-up
// [RULE_09] Software powers down before idle modes
// [RULE_10] A/D clock is system clock divided
// [RULE_11] Conversion lasts sixteen A/D clock periods
// [RULE_12] Positive reference: supply, pin, bandgap
// [RULE_13] Negative reference: ground, pin, DAC output
// [RULE_14] Software avoids unbonded reference pin codes
// [RULE_15] Unimplemented control bits read zero
// [RULE_16] Software clears start before toggling
// [RULE_17] Result split high byte, upper nibble
// [RULE_18] Count from start fall, end together
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_params.svh"
module adc_conversion_control (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic [2:0]                address,
   input  wire logic                      read,
   input  wire logic                      write,
   input  wire logic [31:0]               writedata,
   input  wire logic [3:0]                byteenable,
   output var  logic [31:0]               readdata,
   output var  logic                      waitrequest,
   input  wire logic [11:0]               conv_result,
   output var  logic [7:0]                chan_enable,
   output var  logic                      adc_power_on,
   output var  logic                      conv_reset,
   output var  logic [2:0]                pos_ref_sel,
   output var  logic [2:0]                neg_ref_sel,
   output var  adc_conv_pkg::conv_state_t conv_state,
   output var  logic                      irq
);
   import adc_conv_pkg::*;

   logic        start_r;
   logic        busy_r;
   logic        pdown_r;
   field3_t     chan_r;
   field3_t     div_r;
   logic [1:0]  pos_ref_r;
   logic [1:0]  neg_ref_r;
   logic [11:0] result_r;
   logic        mask_r;
   logic        glob_r;
   logic [3:0]  tick_cnt_r;
   logic        tick;
   logic        int_status;
   logic        acc;
   logic        wr_en;
   logic        wr_lo;
   logic        wr_main;
   logic        start_rise;
   logic        start_fall;
   logic        conv_done;
   logic [31:0] rdata_nxt;

   // Avalon slave: one wait cycle, answer on the second edge
   assign acc     = (read || write) && waitrequest;
   assign wr_en   = write && !waitrequest;
   assign wr_lo   = wr_en && byteenable[0];
   assign wr_main = wr_lo && (address == `REG_MAIN);

   always_ff @(posedge mclk) begin
      if (reset) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !acc;
      end
   end

   // [RULE_15] reserved bits read zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (address == `REG_MAIN) begin
         rdata_nxt[`MAIN_START] = start_r;
         rdata_nxt[`MAIN_BUSY]  = busy_r;
         rdata_nxt[`MAIN_PDOWN] = pdown_r;
         rdata_nxt[2:0]         = chan_r;
      end else if (address == `REG_CLKDIV) begin
         rdata_nxt[2:0] = div_r;
      end else if (address == `REG_REFSEL) begin
         rdata_nxt[3:0] = {pos_ref_r, neg_ref_r};
      end else if (address == `REG_RES_LOW) begin
         // [RULE_17] low nibble zero
         rdata_nxt[7:4] = result_r[3:0];
      end else if (address == `REG_RES_HIGH) begin
         rdata_nxt[7:0] = result_r[11:4];
      end else if (address == `REG_INT_STAT) begin
         rdata_nxt[`INT_DONE_BIT] = int_status;
      end else if (address == `REG_INT_MASK) begin
         rdata_nxt[`INT_DONE_BIT] = mask_r;
      end else begin
         rdata_nxt[`INT_DONE_BIT] = glob_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (acc && read) begin
         readdata <= rdata_nxt;
      end
   end

   // Start bit edges seen at the write that changes it
   assign start_rise = wr_main && writedata[`MAIN_START] && !start_r;
   assign start_fall = wr_main && !writedata[`MAIN_START] && start_r;
   // [RULE_11] done on sixteenth tick
   assign conv_done  = (conv_state == ST_CONV) && tick && (tick_cnt_r == `CONV_LAST);

   // [RULE_07] power-down resets to one
   always_ff @(posedge mclk) begin
      if (reset) begin
         start_r <= 1'b0;
         pdown_r <= `PDOWN_RESET;
         chan_r  <= `CHAN_RESET;
      end else if (wr_main) begin
         start_r <= writedata[`MAIN_START];
         pdown_r <= writedata[`MAIN_PDOWN];
         chan_r  <= writedata[2:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         div_r     <= `DIV_RESET;
         pos_ref_r <= `REF_RESET;
         neg_ref_r <= `REF_RESET;
         mask_r    <= 1'b0;
         glob_r    <= 1'b0;
      end else if (wr_lo) begin
         if (address == `REG_CLKDIV) begin
            div_r <= writedata[2:0];
         end else if (address == `REG_REFSEL) begin
            pos_ref_r <= writedata[`POS_REF_HI:`POS_REF_LO];
            neg_ref_r <= writedata[`NEG_REF_HI:`NEG_REF_LO];
         end else if (address == `REG_INT_MASK) begin
            mask_r <= writedata[`INT_DONE_BIT];
         end else if (address == `REG_GLOB_EN) begin
            glob_r <= writedata[`INT_DONE_BIT];
         end
      end
   end

   // [RULE_02] fall of start launches
   always_ff @(posedge mclk) begin
      if (reset) begin
         conv_state <= ST_IDLE;
      end else begin
         case (conv_state)
            ST_IDLE: begin
               if (start_rise) begin
                  conv_state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (start_fall) begin
                  conv_state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (start_rise) begin
                  conv_state <= ST_HOLD;
               end else if (conv_done) begin
                  conv_state <= ST_IDLE;
               end
            end
            default: begin
               conv_state <= ST_IDLE;
            end
         endcase
      end
   end

   // [RULE_03] reset held while start high
   always_ff @(posedge mclk) begin
      if (reset) begin
         conv_reset <= 1'b0;
      end else if (start_rise) begin
         conv_reset <= 1'b1;
      end else if (start_fall) begin
         conv_reset <= 1'b0;
      end
   end

   // [RULE_04] busy set by start, cleared at end
   always_ff @(posedge mclk) begin
      if (reset) begin
         busy_r <= `BUSY_RESET;
      end else if (start_rise) begin
         busy_r <= 1'b1;
      end else if (conv_done) begin
         busy_r <= 1'b0;
      end
   end

   // [RULE_18] count from start fall
   always_ff @(posedge mclk) begin
      if (reset || start_fall) begin
         tick_cnt_r <= 4'h0;
      end else if ((conv_state == ST_CONV) && tick) begin
         tick_cnt_r <= tick_cnt_r + 4'h1;
      end
   end

   // Result only moves at the end, so a read never tears
   always_ff @(posedge mclk) begin
      if (reset) begin
         result_r <= 12'h000;
      end else if (conv_done) begin
         result_r <= conv_result;
      end
   end

   // [RULE_01] one-hot input routing
   always_ff @(posedge mclk) begin
      if (reset) begin
         chan_enable  <= 8'h00;
         adc_power_on <= 1'b0;
      end else begin
         chan_enable  <= 8'h01 << chan_r;
         adc_power_on <= !pdown_r;
      end
   end

   // [RULE_12] [RULE_13] reference switches
   always_ff @(posedge mclk) begin
      if (reset) begin
         pos_ref_sel <= `REF_SW_FIX;
         neg_ref_sel <= `REF_SW_FIX;
      end else begin
         pos_ref_sel <= (pos_ref_r == `REF_CODE_FIX) ? `REF_SW_FIX :
                        (pos_ref_r == `REF_CODE_PIN) ? `REF_SW_PIN : `REF_SW_ALT;
         neg_ref_sel <= (neg_ref_r == `REF_CODE_FIX) ? `REF_SW_FIX :
                        (neg_ref_r == `REF_CODE_PIN) ? `REF_SW_PIN : `REF_SW_ALT;
      end
   end

   // Divider restarts on launch so every conversion has full periods
   adc_clk_divider u_div (
      .mclk    (mclk),
      .reset   (reset),
      .restart (start_fall),
      .div_sel (div_r),
      .tick    (tick)
   );

   adc_irq_ctrl u_irq (
      .mclk      (mclk),
      .reset     (reset),
      .event_set (conv_done),
      .clr_wr    (wr_lo && (address == `REG_INT_STAT)),
      .clr_bit   (writedata[`INT_DONE_BIT]),
      .mask_en   (mask_r),
      .global_en (glob_r),
      .status    (int_status),
      .irq       (irq)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_chan_route;
      !$past(reset) |-> chan_enable == (8'h01 << $past(chan_r));
   endproperty
   a_chan_route: assert property (p_chan_route) else $error("channel routing mismatch"); // [RULE_01]

   property p_start_launch;
      start_fall |=> conv_state == ST_CONV && !conv_reset;
   endproperty
   a_start_launch: assert property (p_start_launch) else $error("falling start did not launch"); // [RULE_02]

   property p_start_reset;
      start_rise |=> busy_r && conv_reset && conv_state == ST_HOLD;
   endproperty
   a_start_reset: assert property (p_start_reset) else $error("rising start did not reset"); // [RULE_03]

   property p_busy_clear;
      conv_done && !start_rise |=> !busy_r ##0 conv_state == ST_IDLE;
   endproperty
   a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared at end"); // [RULE_04]

   property p_irq_flag;
      conv_done |=> int_status;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("done did not set request"); // [RULE_05]

   property p_irq_gate;
      irq |-> $past(mask_r) && $past(glob_r) && $past(int_status);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without both enables"); // [RULE_06]

   property p_power;
      ##1 adc_power_on == !$past(pdown_r);
   endproperty
   a_power: assert property (p_power) else $error("power output wrong"); // [RULE_07]

   property p_sixteen;
      start_fall && div_r == 3'h1 |-> ##33 conv_done;
   endproperty
   a_sixteen: assert property (p_sixteen) else $error("conversion not sixteen periods"); // [RULE_11]

   property p_fast_conv;
      start_fall && div_r == 3'h0 |-> ##17 conv_done;
   endproperty
   a_fast_conv: assert property (p_fast_conv) else $error("undivided conversion length wrong"); // [RULE_18]

   property p_refs;
      ##1 $onehot(pos_ref_sel) && $onehot(neg_ref_sel);
   endproperty
   a_refs: assert property (p_refs) else $error("reference select not one-hot"); // [RULE_12]

   property p_reserved;
      ##1 waitrequest == 1'b0 && $past(read) && $past(address) == `REG_MAIN |-> readdata[4:3] == 2'h0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RULE_15]

   property p_res_low;
      $past(read) && $past(address) == `REG_RES_LOW && !waitrequest |-> readdata[3:0] == 4'h0;
   endproperty
   a_res_low: assert property (p_res_low) else $error("result low nibble not zero"); // [RULE_17]

   c_conv: cover property (start_fall ##[1:1000] conv_done);
   c_irq: cover property (conv_done ##2 irq);
   c_restart: cover property (conv_state == ST_CONV ##1 conv_state == ST_HOLD);
endmodule // adc_conversion_control
`default_nettype wire

// [verification/adc_conversion_control_tb.sv]
// Self-checking bench for the conversion controller
`timescale 1ns/1ps
`default_nettype none
`include "adc_conv_params.svh"
module adc_conversion_control_tb;
   import adc_conv_pkg::*;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  address = 3'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0]  byteenable = 4'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [11:0] conv_result = 12'h0;
   logic [7:0]  chan_enable;
   logic        adc_power_on;
   logic        conv_reset;
   logic [2:0]  pos_ref_sel;
   logic [2:0]  neg_ref_sel;
   conv_state_t conv_state;
   logic        irq;
   logic [31:0] rdata;
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;

   adc_conversion_control uut (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .conv_result(conv_result), .chan_enable(chan_enable), .adc_power_on(adc_power_on),
      .conv_reset(conv_reset), .pos_ref_sel(pos_ref_sel), .neg_ref_sel(neg_ref_sel),
      .conv_state(conv_state), .irq(irq));

   always #2.5 mclk = ~mclk;

   task automatic end_of_test();
      if (bad_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Longest run is a few divide-by-64 conversions
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic [2:0] a, input logic wr, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      if (wr) begin
         write <= 1'b1;
      end else begin
         read <= 1'b1;
      end
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      rdata = readdata;
      write <= 1'b0;
      read <= 1'b0;
      if (n >= 50) begin
         chk(32'h0, 32'h1, "bus answer");
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'h1);
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string m);
      bus(a, 1'b0, 8'h0, 4'h1);
      chk(rdata, {24'h0, exp}, m);
   endtask

   // Registered outputs lag the register by a cycle
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask

   task automatic t_reset();
      int a;
      rd_chk(`REG_MAIN, 8'h60, "main reset");
      for (a = 1; a < 8; a++) begin
         rd_chk(a[2:0], 8'h00, "reg reset");
      end
      chk(adc_power_on, 1'b0, "power after reset");
      chk(irq, 1'b0, "irq after reset");
   endtask

   task automatic t_bits();
      bus(`REG_MAIN, 1'b1, 8'h1f, 4'h0);
      rd_chk(`REG_MAIN, 8'h60, "byteenable off");
      wr(`REG_MAIN, 8'h1f);
      rd_chk(`REG_MAIN, 8'h47, "main unused bits");
      wr(`REG_CLKDIV, 8'hff);
      rd_chk(`REG_CLKDIV, 8'h07, "clkdiv unused bits");
      wr(`REG_REFSEL, 8'hff);
      rd_chk(`REG_REFSEL, 8'h0f, "refsel unused bits");
      settle();
      chk(adc_power_on, 1'b1, "power on");
      wr(`REG_MAIN, 8'h20);
      settle();
      chk(adc_power_on, 1'b0, "power down");
   endtask

   task automatic t_chan();
      int c;
      for (c = 0; c < 8; c++) begin
         wr(`REG_MAIN, {5'h00, c[2:0]});
         settle();
         chk(chan_enable, 8'h01 << c, "channel route");
      end
   endtask

   task automatic t_ref();
      int v;
      logic [2:0] ep;
      logic [2:0] en;
      for (v = 0; v < 16; v++) begin
         wr(`REG_REFSEL, v[7:0]);
         settle();
         ep = v[3] ? 3'h4 : (v[2] ? 3'h2 : 3'h1);
         en = v[1] ? 3'h4 : (v[0] ? 3'h2 : 3'h1);
         chk(pos_ref_sel, ep, "pos ref");
         chk(neg_ref_sel, en, "neg ref");
      end
   endtask

   // Waits for idle and checks the length in system clocks
   task automatic wait_idle(input int d);
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (conv_state !== ST_IDLE && n < 2000);
      chk(n >= (16 << d) && n <= (16 << d) + 3, 1'b1, "conversion length");
   endtask

   task automatic t_conv(input int d, input logic [11:0] r);
      wr(`REG_INT_STAT, 8'h01);
      rd_chk(`REG_INT_STAT, 8'h00, "status cleared");
      wr(`REG_CLKDIV, d[7:0]);
      conv_result <= r;
      wr(`REG_MAIN, 8'h00);
      wr(`REG_MAIN, 8'h80);
      settle();
      chk(conv_reset, 1'b1, "converter reset");
      chk(conv_state, ST_HOLD, "held state");
      rd_chk(`REG_MAIN, 8'hc0, "busy on start high");
      wr(`REG_MAIN, 8'h00);
      wait_idle(d);
      rd_chk(`REG_MAIN, 8'h00, "busy cleared");
      rd_chk(`REG_INT_STAT, 8'h01, "done status");
      rd_chk(`REG_RES_HIGH, r[11:4], "result high");
      rd_chk(`REG_RES_LOW, {r[3:0], 4'h0}, "result low");
   endtask

   task automatic t_irq();
      int m;
      for (m = 0; m < 4; m++) begin
         wr(`REG_INT_MASK, {7'h0, m[0]});
         wr(`REG_GLOB_EN, {7'h0, m[1]});
         settle();
         chk(irq, m == 3, "irq gating");
      end
      wr(`REG_INT_STAT, 8'h01);
      settle();
      chk(irq, 1'b0, "irq cleared");
   endtask

   // Fall without rise does nothing; rise mid-conversion aborts
   task automatic t_abort();
      wr(`REG_MAIN, 8'h00);
      settle();
      chk(conv_state, ST_IDLE, "fall without rise");
      wr(`REG_CLKDIV, 8'h06);
      wr(`REG_MAIN, 8'h80);
      wr(`REG_MAIN, 8'h00);
      settle();
      chk(conv_state, ST_CONV, "converting");
      chk(conv_reset, 1'b0, "reset released");
      wr(`REG_MAIN, 8'h80);
      settle();
      chk(conv_state, ST_HOLD, "abort to hold");
      rd_chk(`REG_MAIN, 8'hc0, "busy on abort");
      wr(`REG_MAIN, 8'h00);
      wait_idle(6);
      // Both enables still set from the gating test
      settle();
      chk(irq, 1'b1, "irq at end");
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_bits();
      t_chan();
      t_ref();
      // Settling after power-up, before any launch
      repeat (20) @(posedge mclk);
      t_conv(0, 12'ha5c);
      t_conv(1, 12'h3c1);
      t_conv(3, 12'hfff);
      t_conv(6, 12'h001);
      t_conv(0, 12'h800);
      t_irq();
      t_abort();
      wr(`REG_MAIN, 8'h20);
      end_of_test();
   end
endmodule // adc_conversion_control_tb
`default_nettype wire
